// ### asrc_ctrl.sv
// host-side controller for an asynchronous 256K x 16 static ram
`timescale 1ns/100ps
`include "asrc_defines.svh"
module asrc_ctrl
   import asrc_pkg::*;
#(
   parameter int RECOVERY_CYC = `ASRC_RECOVERY_CYC,
   parameter int READ_CYC = `ASRC_READ_CYC,
   parameter int WRITE_CYC = `ASRC_WRITE_CYC,
   parameter int WPULSE_CYC = `ASRC_WPULSE_CYC,
   parameter int FLOAT_CYC = `ASRC_FLOAT_CYC
) (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RST_B_I,
   // user request
   input wire logic REQ_VALID_I,
   output logic REQ_READY_O,
   input wire asrc_req_t REQ_I,
   input wire logic RETENTION_EXIT_I,
   // user answer
   output logic RSP_VALID_O,
   output logic [`ASRC_DATA_W-1:0] RSP_DATA_O,
   // memory pins
   output logic [`ASRC_ADDR_W-1:0] WORD_ADDRESS_O,
   output asrc_ctl_t CTL_O,
   input wire logic [`ASRC_DATA_W-1:0] DATA_LINES_I,
   output logic [`ASRC_DATA_W-1:0] DATA_LINES_O,
   output logic DATA_LINES_OE_O
);
   localparam int CNT_W = 20;
   // ************************************************************
   // pin input synchroniser
   // ************************************************************
   logic [`ASRC_DATA_W-1:0] din_meta_ff;
   logic [`ASRC_DATA_W-1:0] din_sync_ff;
   logic ret_meta_ff;
   logic ret_sync_ff;
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         din_meta_ff <= '0;
         din_sync_ff <= '0;
         ret_meta_ff <= 1'b0;
         ret_sync_ff <= 1'b0;
      end else begin
         din_meta_ff <= DATA_LINES_I;
         din_sync_ff <= din_meta_ff;
         ret_meta_ff <= RETENTION_EXIT_I;
         ret_sync_ff <= ret_meta_ff;
      end
   end
   // ************************************************************
   // access sequencer
   // ************************************************************
   asrc_state_t state_ff, nxt_state;
   asrc_ctl_t ctl_ff, nxt_ctl;
   logic [`ASRC_ADDR_W-1:0] addr_ff, nxt_addr;
   logic [`ASRC_DATA_W-1:0] wdata_ff, nxt_wdata;
   logic oe_ff, nxt_oe;
   logic [`ASRC_DATA_W-1:0] rdata_ff, nxt_rdata;
   logic rvalid_ff, nxt_rvalid;
   logic [1:0] lanes_ff, nxt_lanes;
   logic tmr_load;
   logic [CNT_W-1:0] tmr_val;
   logic tmr_done;

   function automatic logic [CNT_W-1:0] cyc(input int n);
      // every phase lasts at least one cycle; the timer counts n-1 extra
      cyc = (n > 1) ? CNT_W'(n - 1) : '0;
   endfunction

   // idle pins: everything at a definite level, select high
   function automatic asrc_ctl_t ctl_idle();
      ctl_idle = '{device_select_n: 1'b1, output_drive_enable_n: 1'b1,
                   write_strobe_n: 1'b1, low_lane_enable_n: 1'b1,
                   high_lane_enable_n: 1'b1};
   endfunction

   always_comb begin
      nxt_state = state_ff;
      nxt_ctl = ctl_ff;
      nxt_addr = addr_ff;
      nxt_wdata = wdata_ff;
      nxt_oe = oe_ff;
      nxt_rdata = rdata_ff;
      nxt_rvalid = 1'b0;
      nxt_lanes = lanes_ff;
      tmr_load = 1'b0;
      tmr_val = '0;
      case (state_ff)
         ST_RECOVER: begin
            // select stays high for the whole recovery interval
            nxt_ctl = ctl_idle();
            if (tmr_done) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_IDLE: begin
            nxt_ctl = ctl_idle();
            nxt_oe = 1'b0;
            if (ret_sync_ff) begin
               tmr_load = 1'b1;
               tmr_val = cyc(RECOVERY_CYC);
               nxt_state = ST_RECOVER;
            end else if (REQ_VALID_I && REQ_I.lane_en != 2'h0) begin
               nxt_addr = REQ_I.addr;
               nxt_wdata = REQ_I.wdata;
               nxt_lanes = REQ_I.lane_en;
               nxt_ctl.device_select_n = 1'b0;
               nxt_ctl.low_lane_enable_n = ~REQ_I.lane_en[0];
               nxt_ctl.high_lane_enable_n = ~REQ_I.lane_en[1];
               if (REQ_I.write) begin
                  // data driven with the strobe; held until the end of write
                  nxt_ctl.write_strobe_n = 1'b0;
                  nxt_oe = 1'b1;
                  tmr_load = 1'b1;
                  tmr_val = cyc(WPULSE_CYC);
                  nxt_state = ST_WRITE;
               end else begin
                  // our drivers are already off when output drive falls
                  nxt_oe = 1'b0;
                  nxt_ctl.output_drive_enable_n = 1'b0;
                  // full cycle plus two synchroniser stages before sampling
                  tmr_load = 1'b1;
                  tmr_val = cyc(READ_CYC + 2);
                  nxt_state = ST_READ;
               end
            end
         end
         ST_READ: begin
            if (tmr_done) begin
               nxt_rdata = din_sync_ff;
               if (!lanes_ff[0]) begin
                  nxt_rdata[`ASRC_LANE_W-1:0] = '0;
               end
               if (!lanes_ff[1]) begin
                  nxt_rdata[`ASRC_DATA_W-1:`ASRC_LANE_W] = '0;
               end
               nxt_rvalid = 1'b1;
               nxt_ctl = ctl_idle();
               tmr_load = 1'b1;
               tmr_val = cyc(FLOAT_CYC);
               nxt_state = ST_TURN;
            end
         end
         ST_WRITE: begin
            if (tmr_done) begin
               // strobe, select and both lane enables rise together and end the write; address still stable
               nxt_ctl.write_strobe_n = 1'b1;
               nxt_ctl.device_select_n = 1'b1;
               nxt_ctl.low_lane_enable_n = 1'b1;
               nxt_ctl.high_lane_enable_n = 1'b1;
               tmr_load = 1'b1;
               tmr_val = cyc(WRITE_CYC - WPULSE_CYC);
               nxt_state = ST_WEND;
            end
         end
         ST_WEND: begin
            // zero hold, but keep data one extra cycle for margin
            nxt_oe = 1'b0;
            if (tmr_done) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_TURN: begin
            // wait out the memory's float time before the next access
            if (tmr_done) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         state_ff <= ST_IDLE;
         ctl_ff <= '1;
         addr_ff <= '0;
         wdata_ff <= '0;
         oe_ff <= 1'b0;
         rdata_ff <= '0;
         rvalid_ff <= 1'b0;
         lanes_ff <= 2'h0;
      end else begin
         state_ff <= nxt_state;
         ctl_ff <= nxt_ctl;
         addr_ff <= nxt_addr;
         wdata_ff <= nxt_wdata;
         oe_ff <= nxt_oe;
         rdata_ff <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
         lanes_ff <= nxt_lanes;
      end
   end

   asrc_timer #(
      .CNT_W(CNT_W)
   ) u_timer (
      .clk_i(CLK_I),
      .rst_b_i(RST_B_I),
      .load_i(tmr_load),
      .value_i(tmr_val),
      .done_o(tmr_done)
   );

   // ************************************************************
   // outputs
   // ************************************************************
   assign REQ_READY_O = (state_ff == ST_IDLE) && !ret_sync_ff;
   assign RSP_VALID_O = rvalid_ff;
   assign RSP_DATA_O = rdata_ff;
   assign WORD_ADDRESS_O = addr_ff;
   assign CTL_O = ctl_ff;
   assign DATA_LINES_O = wdata_ff;
   assign DATA_LINES_OE_O = oe_ff;
endmodule // asrc_ctrl

// ### asrc_defines.svh
// timing constants and field layout for the async sram word/byte controller
`ifndef ASRC_DEFINES_SVH
`define ASRC_DEFINES_SVH
// ************************************************************
// widths
// ************************************************************
`define ASRC_ADDR_W 18
`define ASRC_DATA_W 16
`define ASRC_LANE_W 8
// ************************************************************
// timing in ns, recovery in ms (slow grade by default) and clock period
// ************************************************************
`define ASRC_CLK_PERIOD_NS 8
`define ASRC_READ_CYCLE_NS 70
`define ASRC_DRIVE_TO_VALID_NS 35
`define ASRC_WRITE_CYCLE_NS 70
`define ASRC_WRITE_PULSE_NS 60
`define ASRC_DATA_SETUP_NS 30
`define ASRC_FLOAT_NS 25
`define ASRC_RECOVERY_MS 5
`define ASRC_NS_PER_MS 1000000
// cycle counts: minimums round up
`define ASRC_CYC_UP(ns) (((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_READ_CYC `ASRC_CYC_UP(`ASRC_READ_CYCLE_NS)
`define ASRC_WRITE_CYC `ASRC_CYC_UP(`ASRC_WRITE_CYCLE_NS)
`define ASRC_WPULSE_CYC `ASRC_CYC_UP(`ASRC_WRITE_PULSE_NS)
`define ASRC_FLOAT_CYC `ASRC_CYC_UP(`ASRC_FLOAT_NS)
`define ASRC_RECOVERY_CYC \
   `ASRC_CYC_UP(`ASRC_RECOVERY_MS * `ASRC_NS_PER_MS)
`endif

// ### asrc_pkg.sv
// types for the async sram word/byte controller
`include "asrc_defines.svh"
package asrc_pkg;
   typedef struct packed {
      logic write;
      logic [1:0] lane_en;
      logic [`ASRC_ADDR_W-1:0] addr;
      logic [`ASRC_DATA_W-1:0] wdata;
   } asrc_req_t;
   typedef struct packed {
      logic device_select_n;
      logic output_drive_enable_n;
      logic write_strobe_n;
      logic low_lane_enable_n;
      logic high_lane_enable_n;
   } asrc_ctl_t;
   typedef enum logic [2:0] {
      ST_RECOVER, ST_IDLE, ST_READ, ST_WRITE, ST_WEND, ST_TURN
   } asrc_state_t;
endpackage

// ### asrc_timer.sv
// down counter that times each phase of a memory access
`timescale 1ns/100ps
module asrc_timer
   import asrc_pkg::*;
#(
   parameter int CNT_W = 20
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // control
   input wire logic load_i,
   input wire logic [CNT_W-1:0] value_i,
   // status
   output logic done_o
);
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   always_comb begin
      if (load_i) begin
         nxt_cnt = value_i;
      end else if (cnt_ff != '0) begin
         nxt_cnt = cnt_ff - 1'b1;
      end else begin
         nxt_cnt = cnt_ff;
      end
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
   // done ignores load: the sequencer loads on done, so gating it would close a loop
   assign done_o = (cnt_ff == '0);
endmodule // asrc_timer

// ### asrc_ctrl_asserts.sv
// concurrent checks on the async sram controller ports
`timescale 1ns/100ps
`include "asrc_defines.svh"
module asrc_ctrl_asserts
   import asrc_pkg::*;
(
   // watched ports
   input wire logic CLK_I,
   input wire logic RST_B_I,
   input wire logic REQ_VALID_I,
   input wire logic REQ_READY_O,
   input wire asrc_req_t REQ_I,
   input wire logic RETENTION_EXIT_I,
   input wire logic RSP_VALID_O,
   input wire logic [`ASRC_DATA_W-1:0] RSP_DATA_O,
   input wire logic [`ASRC_ADDR_W-1:0] WORD_ADDRESS_O,
   input wire asrc_ctl_t CTL_O,
   input wire logic [`ASRC_DATA_W-1:0] DATA_LINES_I,
   input wire logic [`ASRC_DATA_W-1:0] DATA_LINES_O,
   input wire logic DATA_LINES_OE_O
);
   // ************************************************************
   // access phases
   // ************************************************************
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);
   sequence s_wr_start; $fell(CTL_O.write_strobe_n); endsequence
   sequence s_wr_end; $rose(CTL_O.write_strobe_n); endsequence
   sequence s_rd_start; $fell(CTL_O.output_drive_enable_n); endsequence
   chk_strobe_width: assert property (s_wr_start |=> !CTL_O.write_strobe_n [*7])
      else $error("write strobe too short");
   chk_end_together: assert property (s_wr_end |-> $rose(CTL_O.device_select_n))
      else $error("write end not on select");
   chk_data_setup: assert property (s_wr_end |-> $past(DATA_LINES_OE_O, 4)
      && $past(DATA_LINES_O, 4) == $past(DATA_LINES_O)) else $error("write data setup");
   chk_addr_setup: assert property (s_wr_end |-> !$past(CTL_O.device_select_n, 8)
      && $past(WORD_ADDRESS_O, 8) == $past(WORD_ADDRESS_O)) else $error("address setup");
   chk_write_pins: assert property (!CTL_O.write_strobe_n |-> DATA_LINES_OE_O
      && !(CTL_O.low_lane_enable_n && CTL_O.high_lane_enable_n)) else $error("write pins");
   chk_read_answer: assert property (s_rd_start |-> ##11 RSP_VALID_O)
      else $error("read answer late");
   chk_read_length: assert property (s_rd_start |=> !CTL_O.output_drive_enable_n [*8])
      else $error("read cycle too short");
   chk_bus_release: assert property (!CTL_O.output_drive_enable_n |-> !DATA_LINES_OE_O)
      else $error("controller drives during read");
   chk_float_turn: assert property ($rose(CTL_O.output_drive_enable_n) |-> !REQ_READY_O [*4])
      else $error("no float turnaround");
   chk_idle_select: assert property (REQ_READY_O |-> CTL_O.device_select_n)
      else $error("selected while idle");
   chk_recover_hold: assert property ($rose(RETENTION_EXIT_I) |-> ##[1:3] !REQ_READY_O)
      else $error("no recovery wait");
endmodule // asrc_ctrl_asserts
bind asrc_ctrl asrc_ctrl_asserts i_asrc_ctrl_asserts (.*);

// ### asrc_mem_model.sv
// behavioural 256K x 16 async sram seen from the controller
`timescale 1ns/100ps
module asrc_mem_model
   import asrc_pkg::*;
#(
   parameter int ACC_NS = 70
) (
   // pins
   input wire asrc_ctl_t ctl_i,
   input wire logic [17:0] addr_i,
   input wire logic [15:0] din_i,
   output logic [15:0] dout_o
);
   logic [15:0] mem [int];
   logic [15:0] w;
   logic rd_on, rd_lo, rd_hi;
   function automatic logic [15:0] rdm(input int a);
      return mem.exists(a) ? mem[a] : 16'h0;
   endfunction
   // level store: the word follows the data only while select and strobe stay low
   always @(ctl_i or addr_i or din_i) begin
      w = rdm(int'(addr_i));
      if (!ctl_i.device_select_n && !ctl_i.write_strobe_n) begin
         if (!ctl_i.low_lane_enable_n) w[7:0] = din_i[7:0];
         if (!ctl_i.high_lane_enable_n) w[15:8] = din_i[15:8];
         mem[int'(addr_i)] = w;
      end
   end
   assign rd_on = !ctl_i.device_select_n && !ctl_i.output_drive_enable_n
      && ctl_i.write_strobe_n;
   assign rd_lo = rd_on && !ctl_i.low_lane_enable_n;
   assign rd_hi = rd_on && !ctl_i.high_lane_enable_n;
   // a released lane shows the inverse word, so a stale sample never matches
   assign #(ACC_NS) dout_o = {
      rd_hi ? 8'(rdm(int'(addr_i)) >> 8) : 8'(~rdm(int'(addr_i)) >> 8),
      rd_lo ? 8'(rdm(int'(addr_i))) : 8'(~rdm(int'(addr_i)))};
endmodule // asrc_mem_model

// ### asrc_ctrl_test.sv
// self-checking bench for the async sram controller
`timescale 1ns/100ps
module asrc_ctrl_test
   import asrc_pkg::*;
;
   logic CLK_I = 0, RST_B_I = 0, req_valid = 0, ret_exit = 0;
   asrc_req_t req = '0;
   logic req_ready, rsp_valid, oe;
   logic [15:0] rsp_data, dq_i, dq_o, mem_q;
   logic [17:0] addr, a;
   logic [1:0] ln;
   asrc_ctl_t ctl;
   int error_cnt = 0, tests_run = 0, seed = 32'hd788;
   logic [15:0] ref_mem [int];
   logic [15:0] exp_q [$];
   always #4 CLK_I = ~CLK_I;
   asrc_ctrl #(.RECOVERY_CYC(10)) i_asrc_ctrl (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
      .REQ_VALID_I(req_valid), .REQ_READY_O(req_ready), .REQ_I(req),
      .RETENTION_EXIT_I(ret_exit), .RSP_VALID_O(rsp_valid), .RSP_DATA_O(rsp_data),
      .WORD_ADDRESS_O(addr), .CTL_O(ctl), .DATA_LINES_I(dq_i), .DATA_LINES_O(dq_o),
      .DATA_LINES_OE_O(oe));
   asrc_mem_model i_asrc_mem_model (.ctl_i(ctl), .addr_i(addr), .din_i(dq_o),
      .dout_o(mem_q));
   assign dq_i = oe ? dq_o : mem_q;
   function automatic logic [15:0] rdr(input int k);
      return ref_mem.exists(k) ? ref_mem[k] : 16'h0;
   endfunction
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // one request held until the edge that samples ready high
   task automatic access(input logic wr, input logic [1:0] l, input logic [17:0] k,
         input logic [15:0] d);
      logic [15:0] m;
      int n;
      m = {{8{l[1]}}, {8{l[0]}}};
      @(posedge CLK_I);
      #1;
      if (wr) ref_mem[k] = rdr(k) & ~m | d & m;
      else exp_q.push_back(rdr(k) & m);
      req = '{wr, l, k, d};
      req_valid = 1'b1;
      n = 0;
      do begin
         @(posedge CLK_I);
         n++;
      end while (req_ready !== 1'b1 && n < 40);
      #1 req_valid = 1'b0;
      check(16'(n < 40), 16'h1, "request taken");
   endtask
   // ************************************************************
   // answer watcher
   // ************************************************************
   always @(posedge CLK_I) begin
      if (rsp_valid === 1'b1) begin
         if (exp_q.size() == 0) check(16'h1, 16'h0, "spare answer");
         else check(rsp_data, exp_q.pop_front(), "read data");
      end
   end
   initial begin
      #50000;
      error_cnt++;
      $display("unexpected at %0t: watchdog", $time);
      give_verdict();
   end
   // ************************************************************
   // scenarios
   // ************************************************************
   initial begin
      repeat (3) @(posedge CLK_I);
      #1 RST_B_I = 1'b1;
      check(16'(ctl), 16'h1F, "idle pins");
      check(16'(oe), 16'h0, "idle drive");
      ret_exit = 1'b1;
      repeat (3) @(posedge CLK_I);
      #1 ret_exit = 1'b0;
      check(16'(req_ready), 16'h0, "recovery ready");
      check(16'(ctl.device_select_n), 16'h1, "recovery select");
      for (int l = 1; l < 4; l++) begin
         access(1'b1, 2'b11, 18'h3FFFF, 16'hA55A);
         access(1'b1, 2'(l), 18'h3FFFF, 16'h1EE1);
         for (int r = 1; r < 4; r++) access(1'b0, 2'(r), 18'h3FFFF, 16'h0);
      end
      repeat (16) @(posedge CLK_I);
      #1 req = '{1'b1, 2'b00, 18'h5, 16'hFFFF};
      req_valid = 1'b1;
      repeat (4) begin
         @(posedge CLK_I);
         check(16'(ctl.device_select_n), 16'h1, "no lane write");
      end
      #1 req_valid = 1'b0;
      access(1'b0, 2'b11, 18'h5, 16'h0);
      access(1'b1, 2'b11, 18'h0, 16'h00FF);
      access(1'b0, 2'b01, 18'h0, 16'h0);
      repeat (12) begin
         a = 18'($random(seed));
         ln = 2'($random(seed));
         if (ln == 2'b00) ln = 2'b10;
         access(1'b1, 2'b11, a, 16'($random(seed)));
         access(1'b1, ln, a, 16'($random(seed)));
         access(1'b0, 2'($random(seed)) | 2'b01, a, 16'h0);
      end
      repeat (20) @(posedge CLK_I);
      check(16'(exp_q.size()), 16'h0, "answers missing");
      give_verdict();
   end
endmodule // asrc_ctrl_test
